// File: dv/can_message_fifo_control_test.sv
// Register-level tests of the FIFO control block against an engine model
`timescale 1ns/10ps
`include "mfc_map.svh"
module can_message_fifo_control_test;
  logic        clk, reset_n, clk_en, wr, rd;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, got, cfg;
  logic [2:0]  mode;
  logic        done, abort, arb, err, rxs, hdr, dir, busy, irq;
  logic [4:0]  head, tail;
  logic [4:0]  dv [3] = '{5'h00, 5'h01, 5'h1F};
  int          bad_count, check_count;

  mfc_fifo_control uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .operating_mode_field(mode), .eng_tx_done(done),
    .eng_tx_abort(abort), .eng_arb_lost(arb), .eng_tx_error(err), .eng_rx_store(rxs),
    .store_header(hdr), .direction_tx(dir), .flush_busy(busy), .head_ptr(head), .tail_ptr(tail),
    .irq(irq));
  mfc_engine_model eng (.clk(clk), .tx_done(done), .tx_abort(abort), .arb_lost(arb),
    .tx_error(err), .rx_store(rxs));

  // 20 MHz peripheral clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One-cycle strobes; each task starts on a fresh edge so no strobe is assigned twice at once
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  // Advance by one message; pointers show three edges after the write
  task automatic step();
    wreg(`MFC_OFS_CONTROL, cfg | 32'h0000_2000);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic flush();
    int n = 0;
    wreg(`MFC_OFS_CONTROL, cfg | 32'h0000_4000);
    #1 check({31'h0, busy}, 32'h1);
    rreg(`MFC_OFS_CONTROL);
    check(got & 32'h0000_4000, 32'h0000_4000);
    while (got[14] === 1'b1 && n < 10) begin
      rreg(`MFC_OFS_CONTROL);
      n++;
    end
    check(got & 32'h0000_4000, 32'h0000_0000);
    check({31'h0, busy}, 32'h0);
  endtask

  // Watchdog: whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    {reset_n, wr, rd, addr, wdata, mode} = '0;
    clk_en      = 1'b1;
    bad_count   = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rreg(`MFC_OFS_CONTROL);
    check(got, 32'h0000_0000);
    check({31'h0, hdr}, 32'h1);
    // Outside configuration: depth and payload-only refused, holes read zero
    wreg(`MFC_OFS_CONTROL, 32'hFFFF_9F8F);
    rreg(`MFC_OFS_CONTROL);
    check(got, 32'h0000_008F);
    check({31'h0, dir}, 32'h1);
    @(posedge clk);
    mode <= `MFC_MODE_CONFIG;
    wreg(`MFC_OFS_CONTROL, 32'h001F_100F);
    rreg(`MFC_OFS_CONTROL);
    check(got, 32'h001F_100F);
    check({30'h0, dir, hdr}, 32'h0);
    wreg(`MFC_OFS_CONTROL, 32'h001F_108F);
    rreg(`MFC_OFS_CONTROL);
    check({30'h0, dir, hdr}, 32'h3);
    wreg(`MFC_OFS_CONTROL, 32'h001F_000F);
    rreg(`MFC_OFS_CONTROL);
    check({30'h0, dir, hdr}, 32'h1);
    // Frozen clock enable must drop a write; unmapped place reads zero
    @(posedge clk);
    clk_en <= 1'b0;
    wreg(`MFC_OFS_CONTROL, 32'h0000_0000);
    clk_en <= 1'b1;
    wreg(4'h2, 32'hFFFF_FFFF);
    rreg(`MFC_OFS_CONTROL);
    check(got, 32'h001F_000F);
    rreg(4'h2);
    check(got, 32'h0000_0000);
    // Transmit head wraps after depth plus one advances, at the boundary depths
    foreach (dv[i]) begin
      cfg = {11'h000, dv[i], 16'h0080};
      wreg(`MFC_OFS_CONTROL, cfg);
      flush();
      repeat (dv[i]) step();
      check({22'h0, tail, head}, {27'h0, dv[i]});
      step();
      check({22'h0, tail, head}, 32'h0);
    end
    rreg(`MFC_OFS_CONTROL);
    check(got & 32'h0000_2000, 32'h0);
    // Receive FIFO moves the tail only
    cfg = 32'h0003_0000;
    wreg(`MFC_OFS_CONTROL, cfg);
    flush();
    step();
    rreg(`MFC_OFS_POINTERS);
    check(got, 32'h0000_0100);
    // Flags set by the engine; arbitration and error cleared by a control read, abort by completion
    rreg(`MFC_OFS_CONTROL);
    eng.fire(2, 0);
    eng.fire(3, 3);
    rreg(`MFC_OFS_CONTROL);
    check(got & 32'h0000_0070, 32'h0000_0030);
    rreg(`MFC_OFS_CONTROL);
    check(got & 32'h0000_0070, 32'h0);
    eng.fire(1, 0);
    rreg(`MFC_OFS_CONTROL);
    check(got & 32'h0000_0070, 32'h0000_0040);
    eng.fire(0, 5);
    rreg(`MFC_OFS_CONTROL);
    check(got & 32'h0000_0070, 32'h0);
    // Flush clears pointers and all send flags
    eng.fire(1, 0);
    eng.fire(2, 0);
    flush();
    check(got & 32'h0000_0070, 32'h0);
    check({22'h0, tail, head}, 32'h0);
    // Sticky status, mask and level interrupt
    rreg(`MFC_OFS_STATUS);
    wreg(`MFC_OFS_MASK, 32'h0000_0000);
    eng.fire(4, 0);
    repeat (3) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    wreg(`MFC_OFS_MASK, 32'h0000_0008);
    rreg(`MFC_OFS_MASK);
    check(got, 32'h0000_0008);
    check({31'h0, irq}, 32'h1);
    rreg(`MFC_OFS_STATUS);
    check(got, 32'h0000_0008);
    repeat (3) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    print_verdict();
  end
endmodule

// File: dv/mfc_engine_model.sv
// Behavioural protocol engine that raises message events on request
`timescale 1ns/10ps
module mfc_engine_model (
  input  wire logic clk,      // Peripheral clock
  output logic      tx_done,  // Message sent
  output logic      tx_abort, // Send aborted
  output logic      arb_lost, // Arbitration lost
  output logic      tx_error, // Send error
  output logic      rx_store  // Received message stored
);
  logic [4:0] ev_q;
  // Quiet until the bench asks for an event
  initial ev_q = 5'h00;
  assign {rx_store, tx_error, arb_lost, tx_abort, tx_done} = ev_q;
  // One-cycle pulse after an optional delay, so slow answers are covered too
  task automatic fire(input int unsigned k, input int unsigned gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    ev_q <= 5'h01 << k;
    @(posedge clk);
    ev_q <= 5'h00;
  endtask
endmodule

// File: rtl/mfc_fifo_control.sv
// Control and status logic of one CAN message FIFO
// Operation
// - Depth field value plus one gives capacity
// - Flush bit resets FIFO, then self-clears
// - Transmit FIFO advance moves head once
// - Receive FIFO advance moves tail once
// - Direction bit selects transmit or receive
// - Receive payload-only stores data bytes only
// - Receive without payload-only stores whole message
// - Payload-only bit ignored for transmit FIFO
// - Depth and payload-only writable only in configuration
// - Abort flag updates on completion, abort, flush
// - Arbitration and error flags clear on read
// - Unimplemented control bits read as zero
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "mfc_map.svh"
module mfc_fifo_control (
  input  wire logic        clk,            // Peripheral clock, 20 MHz
  input  wire logic        reset_n,        // Async reset, active low
  input  wire logic        clk_en,         // Freezes all state when low
  input  wire logic [3:0]  addr,           // Register byte address
  input  wire logic [31:0] wdata,          // Write data
  input  wire logic        wr,             // Write strobe
  input  wire logic        rd,             // Read strobe
  output logic      [31:0] rdata,          // Read data, cycle after rd
  input  wire logic [2:0]  operating_mode_field, // Controller mode
  input  wire logic        eng_tx_done,    // Engine: message sent
  input  wire logic        eng_tx_abort,   // Engine: send aborted
  input  wire logic        eng_arb_lost,   // Engine: arbitration lost
  input  wire logic        eng_tx_error,   // Engine: send error
  input  wire logic        eng_rx_store,   // Engine: received message stored
  output logic             store_header,   // Store identifier and header
  output logic             direction_tx,   // FIFO is transmit
  output logic             flush_busy,     // Flush in progress
  output logic      [4:0]  head_ptr,       // Head message index
  output logic      [4:0]  tail_ptr,       // Tail message index
  output logic             irq             // Level interrupt
);
  localparam int FLUSH_CYCLES = `MFC_FLUSH_CYCLES;

  mfc_ptr_if pif ();
  mfc_ptr_keeper u_keep (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .pif     (pif)
  );

  // Control fields
  logic [4:0]  depth_q, depth_d;
  logic        payload_q, payload_d;
  logic        txsel_q, txsel_d;
  logic        adv_q, adv_d;
  logic [3:0]  low_q, low_d;
  logic        abort_q, abort_d;
  logic        arb_q, arb_d;
  logic        serr_q, serr_d;
  logic [3:0]  evt_q, evt_d;
  logic [3:0]  mask_q, mask_d;
  logic [31:0] rdata_d;
  logic        irq_d;
  logic        store_d;
  mfc_pkg::mfc_flush_e fst_q, fst_d;
  logic [1:0]  fcnt_q, fcnt_d;

  logic        wr_ctl, rd_ctl, rd_evt, is_cfg, flushing;
  logic [31:0] ctl_view;

  assign wr_ctl   = wr && addr == `MFC_OFS_CONTROL;
  assign rd_ctl   = rd && addr == `MFC_OFS_CONTROL;
  assign rd_evt   = rd && addr == `MFC_OFS_STATUS;
  assign is_cfg   = operating_mode_field == `MFC_MODE_CONFIG;
  assign flushing = fst_q != mfc_pkg::MFC_IDLE;

  // Readable image; unused positions stay zero
  always_comb begin
    ctl_view = 32'h0000_0000;
    ctl_view[`MFC_DEPTH_MSB:`MFC_DEPTH_LSB] = depth_q;
    ctl_view[`MFC_FLUSH_BIT]   = flushing;
    ctl_view[`MFC_ADVANCE_BIT] = adv_q;
    ctl_view[`MFC_PAYLOAD_BIT] = payload_q;
    ctl_view[`MFC_TXSEL_BIT]   = txsel_q;
    ctl_view[`MFC_ABORT_BIT]   = abort_q;
    ctl_view[`MFC_ARBLOST_BIT] = arb_q;
    ctl_view[`MFC_SENDERR_BIT] = serr_q;
    ctl_view[`MFC_LOW_FIELD_MSB:0] = low_q;
  end

  // Flush sequencer: hold pointers clear for a few cycles, then release
  // The done cycle lets software see the bit set once more before it clears
  always_comb begin
    fst_d  = fst_q;
    fcnt_d = fcnt_q;
    case (fst_q)
      mfc_pkg::MFC_IDLE: begin
        if (wr_ctl && wdata[`MFC_FLUSH_BIT]) begin
          fst_d  = mfc_pkg::MFC_FLUSH;
          fcnt_d = 2'h0;
        end
      end
      mfc_pkg::MFC_FLUSH: begin
        fcnt_d = fcnt_q + 2'h1;
        if (fcnt_q == 2'(FLUSH_CYCLES - 1)) begin
          fst_d = mfc_pkg::MFC_DONE;
        end
      end
      mfc_pkg::MFC_DONE: begin
        fst_d = mfc_pkg::MFC_IDLE; // Bit reads clear from here
      end
      default: begin
        fst_d = mfc_pkg::MFC_IDLE;
      end
    endcase
  end

  // Control field updates
  // Advance writes during a flush are dropped so the cleared pointers stay put
  always_comb begin
    depth_d   = depth_q;
    payload_d = payload_q;
    txsel_d   = txsel_q;
    low_d     = low_q;
    adv_d     = 1'b0; // Self-clears after one step
    if (wr_ctl) begin
      if (is_cfg) begin
        depth_d   = wdata[`MFC_DEPTH_MSB:`MFC_DEPTH_LSB];
        payload_d = wdata[`MFC_PAYLOAD_BIT];
      end
      txsel_d = wdata[`MFC_TXSEL_BIT];
      low_d   = wdata[`MFC_LOW_FIELD_MSB:0];
      adv_d   = wdata[`MFC_ADVANCE_BIT] && !flushing;
    end
  end

  // Pointer commands go to the keeper
  assign pif.flush    = fst_q == mfc_pkg::MFC_FLUSH;
  assign pif.adv_head = adv_q && txsel_q;
  assign pif.adv_tail = adv_q && !txsel_q;
  assign pif.depth_m1 = depth_q;

  // Engine status flags; engine events win over the read clear
  // Flush outranks everything, so a reset FIFO never shows stale send flags
  always_comb begin
    abort_d = abort_q;
    arb_d   = arb_q;
    serr_d  = serr_q;
    if (rd_ctl) begin
      arb_d  = 1'b0;
      serr_d = 1'b0;
    end
    if (eng_tx_done || eng_tx_abort) begin
      abort_d = eng_tx_abort;
    end
    if (eng_arb_lost) begin
      arb_d = 1'b1;
    end
    if (eng_tx_error) begin
      serr_d = 1'b1;
    end
    if (pif.flush) begin
      abort_d = 1'b0;
      arb_d   = 1'b0;
      serr_d  = 1'b0;
    end
  end

  // Interrupt status: sticky, cleared by reading it; a new event wins
  always_comb begin
    evt_d  = rd_evt ? 4'h0 : evt_q;
    evt_d  = evt_d | {eng_rx_store, eng_tx_error, eng_arb_lost, eng_tx_abort};
    mask_d = (wr && addr == `MFC_OFS_MASK) ? wdata[3:0] : mask_q;
    irq_d  = |(evt_d & mask_d);
  end

  // Read mux, answer one cycle later; unmapped reads give zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd) begin
      case (addr)
        `MFC_OFS_CONTROL:  rdata_d = ctl_view;
        `MFC_OFS_STATUS:   rdata_d = {28'h0000000, evt_q};
        `MFC_OFS_MASK:     rdata_d = {28'h0000000, mask_q};
        `MFC_OFS_POINTERS: rdata_d = {19'h00000, pif.tail, 3'h0, pif.head};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Header storing only suppressed for receive with payload-only set
  assign store_d = txsel_q || !payload_q;

  // All state registers; everything zero at reset except store_header (one) and the flush state (MFC_IDLE)
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      depth_q      <= 5'h00;
      payload_q    <= 1'b0;
      txsel_q      <= 1'b0;
      adv_q        <= 1'b0;
      low_q        <= 4'h0;
      abort_q      <= 1'b0;
      arb_q        <= 1'b0;
      serr_q       <= 1'b0;
      evt_q        <= 4'h0;
      mask_q       <= 4'h0;
      fst_q        <= mfc_pkg::MFC_IDLE;
      fcnt_q       <= 2'h0;
      rdata        <= 32'h0000_0000;
      irq          <= 1'b0;
      store_header <= 1'b1;
      direction_tx <= 1'b0;
      flush_busy   <= 1'b0;
      head_ptr     <= 5'h00;
      tail_ptr     <= 5'h00;
    end else if (clk_en) begin
      depth_q      <= depth_d;
      payload_q    <= payload_d;
      txsel_q      <= txsel_d;
      adv_q        <= adv_d;
      low_q        <= low_d;
      abort_q      <= abort_d;
      arb_q        <= arb_d;
      serr_q       <= serr_d;
      evt_q        <= evt_d;
      mask_q       <= mask_d;
      fst_q        <= fst_d;
      fcnt_q       <= fcnt_d;
      rdata        <= rdata_d;
      irq          <= irq_d;
      store_header <= store_d;
      direction_tx <= txsel_d;
      flush_busy   <= fst_d != mfc_pkg::MFC_IDLE;
      head_ptr     <= pif.head;
      tail_ptr     <= pif.tail;
    end
  end

  // Register bus: refused fields, self-clearing bits, holes
  a_depth_locked: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_ctl && !is_cfg |=> $stable(depth_q) && $stable(payload_q))
    else $error("depth changed outside configuration mode");
  a_advance_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && adv_q |=> !adv_q || $past(wr_ctl))
    else $error("advance bit stuck");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    $past(rd_ctl) && $past(clk_en) |-> rdata[31:21] == 11'h000 && rdata[11:8] == 4'h0 && !rdata[15])
    else $error("reserved bits read nonzero");
  a_direction_out: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && wr_ctl |=> direction_tx == $past(wdata[`MFC_TXSEL_BIT]))
    else $error("direction output does not follow write");

  // Flush and pointer movement
  a_flush_clears: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && fst_q == mfc_pkg::MFC_IDLE && wr_ctl && wdata[`MFC_FLUSH_BIT] |=> flushing ##[1:8] !flushing)
    else $error("flush bit did not self-clear");
  a_flush_zeroes: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && pif.flush |=> pif.head == 5'h00 && pif.tail == 5'h00 && !abort_q && !arb_q && !serr_q)
    else $error("flush left pointers or flags set");
  a_busy_mirror: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> flush_busy == flushing)
    else $error("busy output disagrees with flush state");
  a_tail_moves: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && adv_q && !txsel_q && !pif.flush |=> pif.tail != $past(pif.tail) || depth_q == 5'h00)
    else $error("tail did not advance");

  // Engine flags
  a_arb_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && rd_ctl && !eng_arb_lost |=> !arb_q)
    else $error("arbitration flag not cleared on read");
  a_err_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && rd_ctl && !eng_tx_error |=> !serr_q)
    else $error("send error flag not cleared on read");
  a_abort_update: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && eng_tx_abort && !pif.flush |=> abort_q)
    else $error("abort flag not set");
  a_done_abort: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && eng_tx_done && !eng_tx_abort && !pif.flush |=> !abort_q)
    else $error("abort flag not cleared by completion");

  // Header storing per direction
  a_header_select: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !txsel_q && payload_q |=> !store_header)
    else $error("payload-only receive still stores header");
  a_header_full: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && !txsel_q && !payload_q |=> store_header)
    else $error("full receive drops header");
  a_header_transmit: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && txsel_q |=> store_header)
    else $error("transmit FIFO affected by payload-only bit");

  // Registered outputs follow their sources
  a_pointer_out: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> head_ptr == $past(pif.head) && tail_ptr == $past(pif.tail))
    else $error("pointer outputs lag wrongly");
  a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> irq == |(evt_q & mask_q))
    else $error("interrupt level wrong");

  // Main scenarios
  c_flush_seen:   cover property (@(posedge clk) fst_q == mfc_pkg::MFC_DONE);
  c_head_wrap:    cover property (@(posedge clk) pif.adv_head && pif.head == depth_q && depth_q != 5'h00);
  c_tail_step:    cover property (@(posedge clk) pif.adv_tail && depth_q != 5'h00);
  c_cfg_refused:  cover property (@(posedge clk) wr_ctl && !is_cfg);
  c_irq_raised:   cover property (@(posedge clk) irq);
endmodule

// File: rtl/mfc_map.svh
// Register offsets, field positions, reset values and timing counts of the FIFO control block
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH
`define MFC_ADDR_W          4
`define MFC_OFS_CONTROL     4'h0
`define MFC_OFS_STATUS      4'h4
`define MFC_OFS_MASK        4'h8
`define MFC_OFS_POINTERS    4'hC
`define MFC_DEPTH_LSB       16
`define MFC_DEPTH_MSB       20
`define MFC_FLUSH_BIT       14
`define MFC_ADVANCE_BIT     13
`define MFC_PAYLOAD_BIT     12
`define MFC_TXSEL_BIT       7
`define MFC_ABORT_BIT       6
`define MFC_ARBLOST_BIT     5
`define MFC_SENDERR_BIT     4
`define MFC_LOW_FIELD_MSB   3
`define MFC_CONTROL_RESET   32'h0000_0000
`define MFC_CONTROL_WMASK   32'h001F_708F
`define MFC_MODE_CONFIG     3'h4
`define MFC_FLUSH_CYCLES    2
`define MFC_EVT_W           4
`endif

// File: rtl/mfc_pkg.sv
// Types shared by the FIFO control block
package mfc_pkg;
  typedef enum logic [2:0] {
    MFC_IDLE  = 3'h1,
    MFC_FLUSH = 3'h2,
    MFC_DONE  = 3'h4
  } mfc_flush_e;
  typedef logic [4:0] mfc_ptr_t;
endpackage

// File: rtl/mfc_ptr_if.sv
// Pointer and flush signals between control logic and pointer keeper
`timescale 1ns/10ps
interface mfc_ptr_if;
  logic                flush;
  logic                adv_head;
  logic                adv_tail;
  logic [4:0]          depth_m1;
  mfc_pkg::mfc_ptr_t   head;
  mfc_pkg::mfc_ptr_t   tail;
  modport ctl (output flush, output adv_head, output adv_tail, output depth_m1, input head, input tail);
  modport keep (input flush, input adv_head, input adv_tail, input depth_m1, output head, output tail);
endinterface

// File: rtl/mfc_ptr_keeper.sv
// Head and tail pointers of one message FIFO, wrapping at the programmed depth
`timescale 1ns/10ps
`include "mfc_map.svh"
module mfc_ptr_keeper (
  input  wire logic clk,     // Peripheral clock
  input  wire logic reset_n, // Async reset, active low
  input  wire logic clk_en,  // Freezes all state when low
  mfc_ptr_if.keep   pif      // Pointer control
);
  mfc_pkg::mfc_ptr_t head_q, head_d, tail_q, tail_d;

  // Wrap at depth field plus one messages
  function automatic mfc_pkg::mfc_ptr_t bump(input mfc_pkg::mfc_ptr_t p, input logic [4:0] last);
    bump = (p >= last) ? 5'h00 : p + 5'h01;
  endfunction

  // Next pointer values; flush returns both to zero
  always_comb begin
    head_d = head_q;
    tail_d = tail_q;
    if (pif.flush) begin
      head_d = 5'h00;
      tail_d = 5'h00;
    end else begin
      if (pif.adv_head) begin
        head_d = bump(head_q, pif.depth_m1);
      end
      if (pif.adv_tail) begin
        tail_d = bump(tail_q, pif.depth_m1);
      end
    end
  end

  // Pointer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      head_q <= 5'h00;
      tail_q <= 5'h00;
    end else if (clk_en) begin
      head_q <= head_d;
      tail_q <= tail_d;
    end
  end

  assign pif.head = head_q;
  assign pif.tail = tail_q;

  a_head_single_step: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && pif.adv_head && !pif.flush && head_q < pif.depth_m1 |=> head_q == $past(head_q) + 5'h01)
    else $error("head did not advance by one");
endmodule
